// ===== rtl/aig_gate_flags.sv
// module: interrupt service gate, permit, overflow and test flags
`timescale 1ns/10ps
`default_nettype none
module aig_gate_flags
  import aig_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire aig_cmd_t          cmd,
  input  wire aig_seq_t          seq,
  input  wire aig_status_t       stat,
  input  wire logic [WORD_W-1:0] instrWord,
  input  wire logic [WORD_W-1:0] accumulator,
  input  wire logic [WORD_W-1:0] restoreWord,
  input  wire logic [ADDR_W-1:0] progCounter,
  input  wire logic              lockoutSwitchPin,
  input  wire logic              interruptRequest,
  input  wire logic              interruptInhibitable,
  input  wire logic [LEVEL_W-1:0] interruptLevel,
  output logic                   interrupt_service_gate,
  output logic                   interruptAccept,
  output logic                   interrupt_permit_flag,
  output logic                   permit_clear_condition,
  output logic                   clearPriority,
  output logic                   echo_interrupt_request,
  output logic                   interrupt_module_addresses_memory,
  output logic                   memory_address_bit_seven,
  output logic [ADDR_W-1:0]      memAddr,
  output logic                   overflow_flag,
  output logic                   test_flag,
  output logic                   branchTaken,
  output logic [WORD_W-1:0]      savedWord
);

  aig_state_t state;
  aig_state_t next_state;

  // ----------------------------------------------------------------
  // lockout pin synchroniser
  // ----------------------------------------------------------------
  logic lockMeta;
  logic lockSync;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockMeta <= 1'b1;
      lockSync <= 1'b1;
    end else begin
      lockMeta <= lockoutSwitchPin;
      lockSync <= lockMeta;
    end
  end

  // ----------------------------------------------------------------
  // gate decode
  // ----------------------------------------------------------------
  logic envelope3;
  logic noState4Cmd;
  logic suppressCmd;
  logic serviceGate;
  logic wantInterrupt;

  assign envelope3 = seq.state4 & seq.timing_envelope_a & seq.timing_envelope_c;
  assign noState4Cmd = cmd.branch_unconditional_cmd | cmd.branch_on_test_set_cmd
                     | cmd.branch_on_test_reset_cmd | cmd.test_index_high_cmd;
  assign suppressCmd = cmd.count_ones_cmd | cmd.count_zeros_cmd
                     | cmd.count_ones_variant_cmd | cmd.count_zeros_variant_cmd
                     | cmd.load_program_register_cmd | cmd.load_program_counter_cmd
                     | cmd.store_place_and_branch_cmd | cmd.jump_no_overflow_cmd
                     | cmd.jump_device_not_ready_cmd | cmd.jump_data_ready_cmd
                     | cmd.jump_channel_busy_cmd | cmd.load_index_cmd
                     | stat.volumeDifference | stat.trapError;
  assign serviceGate = envelope3 & ~noState4Cmd & ~suppressCmd & ~lockSync;
  assign wantInterrupt = interruptRequest & serviceGate
                       & (~interruptInhibitable | state.permit);

  assign interrupt_service_gate = serviceGate;
  assign interruptAccept        = wantInterrupt;

  // ----------------------------------------------------------------
  // permit clear and set conditions
  // ----------------------------------------------------------------
  logic permitClear;
  logic permitSet;
  assign permitClear = envelope3 & seq.timing_envelope_b
                     & (cmd.store_place_and_branch_cmd | cmd.inhibit_interrupt_cmd
                        | cmd.load_program_register_cmd)
                     & ~stat.volumeDifference & ~stat.protectError;
  assign permitSet = seq.state4 & seq.last_pulse
                   & (cmd.permit_interrupt_cmd
                      | (cmd.load_program_register_cmd & instrWord[PERMIT_SET_BIT]));
  assign permit_clear_condition = permitClear;
  assign clearPriority          = permitClear;

  // ----------------------------------------------------------------
  // echo request
  // ----------------------------------------------------------------
  assign echo_interrupt_request = stat.blockLastCharLastWord
                                | (cmd.decrement_tally_cmd & stat.tallyZeroToMinusOne);

  // ----------------------------------------------------------------
  // overflow and test sources
  // ----------------------------------------------------------------
  logic arithCmd;
  logic shiftOvf;
  logic testLoadCmd;
  logic branchOnTest;
  assign arithCmd = cmd.add_cmd | cmd.subtract_cmd | cmd.multiply_cmd | cmd.divide_cmd;
  // stat.arithOverflow: magnitude past SINGLE_MAG_W, or DOUBLE_MAG_W when doubleLength
  assign shiftOvf = cmd.group_three_command & instrWord[SHIFT_OVF_BIT] & stat.leftShift
                  & (accumulator[SIGN_BIT] ^ accumulator[NEXT_BIT]);
  assign testLoadCmd = cmd.decrement_tally_cmd | cmd.group_one_command
                     | cmd.test_index_high_cmd;
  assign branchOnTest = (cmd.branch_on_test_set_cmd & state.test)
                      | (cmd.branch_on_test_reset_cmd & ~state.test);
  assign branchTaken = branchOnTest | (cmd.jump_no_overflow_cmd & ~state.overflow);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (permitClear) begin
      next_state.permit = 1'b0;
    end else if (permitSet) begin
      next_state.permit = 1'b1;
    end
    if (seq.exec_step) begin
      if (cmd.load_program_register_cmd) begin
        next_state.overflow = restoreWord[SAVE_OVF_BIT];
        next_state.test     = restoreWord[SAVE_TEST_BIT];
      end else begin
        if (cmd.jump_no_overflow_cmd) begin
          next_state.overflow = 1'b0;
        end
        if ((arithCmd & stat.arithOverflow) | shiftOvf) begin
          next_state.overflow = 1'b1;
        end
        if (cmd.group_one_set_cmd) begin
          next_state.test = 1'b1;
        end else if (cmd.group_one_clear_test_cmd) begin
          next_state.test = 1'b0;
        end else if (testLoadCmd) begin
          next_state.test = stat.testOutcome;
        end
      end
      if (cmd.store_place_and_branch_cmd) begin
        next_state.savedWord = '0;
        next_state.savedWord[SAVE_OVF_BIT]  = state.overflow;
        next_state.savedWord[SAVE_TEST_BIT] = state.test;
      end
    end
    if (stat.protectError) begin
      next_state.savedWord = instrWord;
    end
    // interrupt taken in envelope, served at next state 1
    if (wantInterrupt) begin
      next_state.intPending = 1'b1;
    end
    next_state.intAccess = 1'b0;
    if (state.intPending & seq.state1) begin
      next_state.intPending = 1'b0;
      next_state.intAccess  = 1'b1;
      next_state.memAddr    = '0;
      next_state.memAddr[MA_FORCE_BIT] = 1'b1;
      next_state.memAddr[LEVEL_W-1:0]  = interruptLevel;
    end else if (stat.protectError) begin
      next_state.memAddr = PROTECT_EXIT_ADDR;
    end else if (stat.stallAlarm) begin
      next_state.memAddr = STALL_EXIT_ADDR;
    end else begin
      next_state.memAddr = progCounter;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state.permit     <= RST_PERMIT;
      state.overflow   <= RST_OVF;
      state.test       <= RST_TEST;
      state.intPending <= 1'b0;
      state.intAccess  <= 1'b0;
      state.memAddr    <= '0;
      state.savedWord  <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign interrupt_permit_flag             = state.permit;
  assign overflow_flag                     = state.overflow;
  assign test_flag                         = state.test;
  assign interrupt_module_addresses_memory = state.intAccess;
  assign memory_address_bit_seven          = state.intAccess;
  assign memAddr                           = state.memAddr;
  assign savedWord                         = state.savedWord;

endmodule
`default_nettype wire

// ===== rtl/aig_pkg.sv
// package: constants and types for the interrupt gate and status flag block
// Contract
// - service gate only in timing 3 envelope of sequence state 4
// - branch, test-branch and index-high commands never open the gate
// - listed commands, volume difference or trap error suppress the gate
// - console lockout holds the service gate closed
// - cleared permit flag blocks inhibitable interrupts; others need only the gate
// - permit cleared in envelope of state 4 by store-branch, inhibit, load-program-register
// - permit clear also tells interrupt module to clear priority flip-flops
// - permit set at last pulse of state 4 by permit or load-program-register bit 21
// - echo request on last block-transfer character or tally stepping 0 to -1
// - interrupt access in next state 1 addresses memory from interrupt module
// - interrupt access forces address bit 7; module supplies bits 6 to 0
// - overflow set when arithmetic result exceeds 23 or 46 bit magnitude
// - group-3 left shift with bit 5 sets overflow when accumulator bits 23, 22 differ
// - jump-no-overflow tests overflow flag and clears it
// - store-and-branch saves overflow and test; load-program-register restores both
// - tally, group-1 and index-high commands load test flag with tested outcome
// - test-branch commands branch on current test flag
// - group-1 set sets test flag; group-1 clear-test clears it
// - protect error exits via location 20 octal, saves instruction word at 21
// - stall alarm error exits via location 24 octal
// - data words are 24 bits, bit 23 sign and most significant
package aig_pkg;

  localparam int WORD_W   = 24;
  localparam int ADDR_W   = 15;
  localparam int SIGN_BIT = 23;
  localparam int NEXT_BIT = 22;
  localparam int PERMIT_SET_BIT = 21;
  localparam int SHIFT_OVF_BIT  = 5;
  localparam int MA_FORCE_BIT   = 7;
  localparam int LEVEL_W        = 7;
  localparam int SINGLE_MAG_W   = 23;
  localparam int DOUBLE_MAG_W   = 46;
  // saved flag positions in the stored word
  localparam int SAVE_OVF_BIT   = 23;
  localparam int SAVE_TEST_BIT  = 22;

  localparam logic [ADDR_W-1:0] PROTECT_EXIT_ADDR = 15'h0010;
  localparam logic [ADDR_W-1:0] PROTECT_SAVE_ADDR = 15'h0011;
  localparam logic [ADDR_W-1:0] STALL_EXIT_ADDR   = 15'h0014;

  localparam logic RST_PERMIT = 1'b0;
  localparam logic RST_OVF    = 1'b0;
  localparam logic RST_TEST   = 1'b0;

  // one-hot command decode from the instruction decoder
  typedef struct packed {
    logic branch_unconditional_cmd;
    logic branch_on_test_set_cmd;
    logic branch_on_test_reset_cmd;
    logic test_index_high_cmd;
    logic count_ones_cmd;
    logic count_zeros_cmd;
    logic count_ones_variant_cmd;
    logic count_zeros_variant_cmd;
    logic load_program_register_cmd;
    logic load_program_counter_cmd;
    logic store_place_and_branch_cmd;
    logic jump_no_overflow_cmd;
    logic jump_device_not_ready_cmd;
    logic jump_data_ready_cmd;
    logic jump_channel_busy_cmd;
    logic load_index_cmd;
    logic permit_interrupt_cmd;
    logic inhibit_interrupt_cmd;
    logic decrement_tally_cmd;
    logic add_cmd;
    logic subtract_cmd;
    logic multiply_cmd;
    logic divide_cmd;
    logic group_one_command;
    logic group_one_set_cmd;
    logic group_one_clear_test_cmd;
    logic group_three_command;
  } aig_cmd_t;

  // sequencer timing
  typedef struct packed {
    logic state1;
    logic state4;
    logic timing_envelope_a;
    logic timing_envelope_b;
    logic timing_envelope_c;
    logic last_pulse;
    logic exec_step;
  } aig_seq_t;

  // arithmetic and error status for this cycle
  typedef struct packed {
    logic              arithOverflow;
    logic              doubleLength;
    logic              leftShift;
    logic              testOutcome;
    logic              tallyZeroToMinusOne;
    logic              blockLastCharLastWord;
    logic              volumeDifference;
    logic              trapError;
    logic              protectError;
    logic              stallAlarm;
  } aig_status_t;

  typedef struct packed {
    logic permit;
    logic overflow;
    logic test;
    logic intPending;
    logic intAccess;
    logic [ADDR_W-1:0] memAddr;
    logic [WORD_W-1:0] savedWord;
  } aig_state_t;

endpackage

// ===== verification/aig_gate_flags_props.sv
// checker: port-level properties of the gate and flag block
`timescale 1ns/10ps
`default_nettype none
module aig_gate_flags_props
  import aig_pkg::*;
(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire aig_cmd_t           cmd,
  input wire aig_seq_t           seq,
  input wire aig_status_t        stat,
  input wire logic [WORD_W-1:0]  restoreWord,
  input wire logic               lockoutSwitchPin,
  input wire logic               interruptInhibitable,
  input wire logic [LEVEL_W-1:0] interruptLevel,
  input wire logic               interrupt_service_gate,
  input wire logic               interruptAccept,
  input wire logic               interrupt_permit_flag,
  input wire logic               permit_clear_condition,
  input wire logic               clearPriority,
  input wire logic               echo_interrupt_request,
  input wire logic               interrupt_module_addresses_memory,
  input wire logic               memory_address_bit_seven,
  input wire logic [ADDR_W-1:0]  memAddr,
  input wire logic               overflow_flag,
  input wire logic               test_flag,
  input wire logic               branchTaken
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_locked; lockoutSwitchPin [*3]; endsequence
  sequence s_clear_then_low; clearPriority ##1 !interrupt_permit_flag; endsequence
  property p_gate; interrupt_service_gate |-> seq.state4 && seq.timing_envelope_a
    && seq.timing_envelope_c && !(cmd.branch_unconditional_cmd || cmd.branch_on_test_set_cmd
    || cmd.branch_on_test_reset_cmd || cmd.test_index_high_cmd); endproperty
  a_gate: assert property (p_gate) else $error("gate open outside envelope");
  property p_supp; interrupt_service_gate |-> !(cmd.count_ones_cmd || cmd.count_zeros_cmd
    || cmd.count_ones_variant_cmd || cmd.count_zeros_variant_cmd || cmd.load_index_cmd
    || cmd.load_program_register_cmd || cmd.load_program_counter_cmd
    || cmd.store_place_and_branch_cmd || cmd.jump_no_overflow_cmd || cmd.jump_data_ready_cmd
    || cmd.jump_device_not_ready_cmd || cmd.jump_channel_busy_cmd
    || stat.volumeDifference || stat.trapError); endproperty
  a_supp: assert property (p_supp) else $error("gate open after suppressing cmd");
  property p_lock; s_locked |-> !interrupt_service_gate; endproperty
  a_lock: assert property (p_lock) else $error("gate open under lockout");
  property p_inhib; interruptAccept && interruptInhibitable |-> interrupt_permit_flag; endproperty
  a_inhib: assert property (p_inhib) else $error("inhibitable accepted");
  property p_clear; permit_clear_condition |-> s_clear_then_low; endproperty
  a_clear: assert property (p_clear) else $error("permit clear failed");
  property p_set; seq.state4 && seq.last_pulse && cmd.permit_interrupt_cmd
    && !permit_clear_condition |=> interrupt_permit_flag; endproperty
  a_set: assert property (p_set) else $error("permit not set");
  property p_echo; stat.blockLastCharLastWord |-> echo_interrupt_request; endproperty
  a_echo: assert property (p_echo) else $error("echo missing");
  property p_addr; interrupt_module_addresses_memory |-> memory_address_bit_seven
    && memAddr == {7'h00, 1'b1, $past(interruptLevel)}; endproperty
  a_addr: assert property (p_addr) else $error("interrupt address wrong");
  property p_jno; seq.exec_step && cmd.jump_no_overflow_cmd && !stat.arithOverflow
    |=> !overflow_flag; endproperty
  a_jno: assert property (p_jno) else $error("overflow not cleared");
  property p_restore; seq.exec_step && cmd.load_program_register_cmd |=>
    overflow_flag == $past(restoreWord[SAVE_OVF_BIT])
    && test_flag == $past(restoreWord[SAVE_TEST_BIT]); endproperty
  a_restore: assert property (p_restore) else $error("flags not restored");
  property p_bts; cmd.branch_on_test_set_cmd |-> branchTaken == test_flag; endproperty
  a_bts: assert property (p_bts) else $error("test branch wrong");
  property p_hold; !seq.exec_step |=> $stable(test_flag); endproperty
  a_hold: assert property (p_hold) else $error("test flag moved");
endmodule
bind aig_gate_flags aig_gate_flags_props u_props (.clk, .sys_rst, .cmd, .seq, .stat,
  .restoreWord, .lockoutSwitchPin, .interruptInhibitable, .interruptLevel,
  .interrupt_service_gate, .interruptAccept, .interrupt_permit_flag, .permit_clear_condition,
  .clearPriority, .echo_interrupt_request, .interrupt_module_addresses_memory,
  .memory_address_bit_seven, .memAddr, .overflow_flag, .test_flag, .branchTaken);
`default_nettype wire

// ===== verification/aig_int_model.sv
// partner: behavioural interrupt module facing the gate block
`timescale 1ns/10ps
`default_nettype none
module aig_int_model
  import aig_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               raise,
  input  wire logic               raiseInhib,
  input  wire logic [LEVEL_W-1:0] raiseLevel,
  input  wire logic               interruptAccept,
  input  wire logic               clearPriority,
  output logic                    interruptRequest,
  output logic                    interruptInhibitable,
  output logic [LEVEL_W-1:0]      interruptLevel
);
  // echo is ignored: no tally here ran from an interrupt
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interruptRequest <= 1'b0;
      interruptInhibitable <= 1'b0;
      interruptLevel <= '0;
    end else if (raise) begin
      interruptRequest <= 1'b1;
      interruptInhibitable <= raiseInhib;
      interruptLevel <= raiseLevel;
    end else if (interruptAccept || clearPriority) begin
      interruptRequest <= 1'b0;
    end else if (!interruptRequest) begin
      interruptLevel <= ~interruptLevel;
    end
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// testbench: directed and random stimulus against a flag and gate model
`timescale 1ns/10ps
`default_nettype none
module testbench
  import aig_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, lock = 1'b0, raise = 1'b0, raiseInhib = 1'b0;
  aig_cmd_t cmd = '0;
  aig_seq_t seq = '0;
  aig_status_t stat = '0;
  logic [WORD_W-1:0] instrWord = '0, accumulator = '0, restoreWord = '0, saved;
  logic [ADDR_W-1:0] memAddr;
  logic [LEVEL_W-1:0] raiseLevel = '0, level;
  logic req, inhib, gate, acc, permit, pcc, clrPri, echo, imam, ovf, tst, bit7, brTaken;
  logic ePermit = 1'b0, eOvf = 1'b0, eTst = 1'b0;
  logic [WORD_W-1:0] eSaved = '0;
  int err_count = 0, n_checks = 0, seed = 32'hFC98;
  always #4 clk = ~clk;
  aig_gate_flags dut (.clk(clk), .sys_rst(sys_rst), .cmd(cmd), .seq(seq), .stat(stat),
    .instrWord(instrWord), .accumulator(accumulator), .restoreWord(restoreWord),
    .progCounter(15'h1234), .lockoutSwitchPin(lock), .interruptRequest(req),
    .interruptInhibitable(inhib), .interruptLevel(level), .interrupt_service_gate(gate),
    .interruptAccept(acc), .interrupt_permit_flag(permit), .permit_clear_condition(pcc),
    .clearPriority(clrPri), .echo_interrupt_request(echo),
    .interrupt_module_addresses_memory(imam), .memory_address_bit_seven(bit7),
    .memAddr(memAddr), .overflow_flag(ovf), .test_flag(tst), .branchTaken(brTaken),
    .savedWord(saved));
  aig_int_model partner (.clk(clk), .sys_rst(sys_rst), .raise(raise), .raiseInhib(raiseInhib),
    .raiseLevel(raiseLevel), .interruptAccept(acc), .clearPriority(clrPri),
    .interruptRequest(req), .interruptInhibitable(inhib), .interruptLevel(level));
  task automatic chk(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    n_checks++;
    if (e !== g) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic expGate();
    return seq.state4 & seq.timing_envelope_a & seq.timing_envelope_c & ~lock & ~|{
      cmd[26:12], cmd.load_index_cmd, stat.volumeDifference, stat.trapError};
  endfunction
  // ------------------------------------------------------------
  // one cycle: comb checks, model step, registered checks
  // ------------------------------------------------------------
  task automatic tick();
    logic clr, set, eg;
    #1;
    eg = expGate();
    clr = seq.state4 & seq.timing_envelope_a & seq.timing_envelope_b & seq.timing_envelope_c
      & (cmd.store_place_and_branch_cmd | cmd.inhibit_interrupt_cmd
      | cmd.load_program_register_cmd) & ~stat.volumeDifference & ~stat.protectError;
    set = seq.state4 & seq.last_pulse & (cmd.permit_interrupt_cmd
      | cmd.load_program_register_cmd & instrWord[PERMIT_SET_BIT]);
    chk("gate", eg, gate);
    chk("accept", req & eg & (~inhib | ePermit), acc);
    chk("clear", {clr, clr}, {pcc, clrPri});
    chk("echo", stat.blockLastCharLastWord
      | cmd.decrement_tally_cmd & stat.tallyZeroToMinusOne, echo);
    chk("branch", cmd.branch_on_test_set_cmd & eTst
      | cmd.branch_on_test_reset_cmd & ~eTst
      | cmd.jump_no_overflow_cmd & ~eOvf, brTaken);
    if (seq.exec_step && cmd.store_place_and_branch_cmd) eSaved = {eOvf, eTst, 22'h0};
    if (stat.protectError) eSaved = instrWord;
    ePermit = clr ? 1'b0 : (set ? 1'b1 : ePermit);
    if (seq.exec_step && cmd.load_program_register_cmd) begin
      {eOvf, eTst} = restoreWord[SAVE_OVF_BIT:SAVE_TEST_BIT];
    end else if (seq.exec_step) begin
      if (cmd.jump_no_overflow_cmd) eOvf = 1'b0;
      if (|cmd[7:4] & stat.arithOverflow) eOvf = 1'b1;
      if (cmd.group_three_command & instrWord[SHIFT_OVF_BIT] & stat.leftShift
        & (accumulator[SIGN_BIT] ^ accumulator[NEXT_BIT])) eOvf = 1'b1;
      if (cmd.decrement_tally_cmd | cmd.group_one_command | cmd.test_index_high_cmd)
        eTst = stat.testOutcome;
      if (cmd.group_one_set_cmd) eTst = 1'b1;
      if (cmd.group_one_clear_test_cmd) eTst = 1'b0;
    end
    @(negedge clk);
    chk("permit", ePermit, permit);
    chk("saved", eSaved, saved);
    chk("overflow", eOvf, ovf);
    chk("test", eTst, tst);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(20000 * 8);
    err_count++;
    final_report();
  end
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("reset", 3'b000, {permit, ovf, tst});
    lock = 1'b1;
    repeat (3) @(negedge clk);
    seq = 7'b0110100;
    tick();
    lock = 1'b0;
    seq = '0;
    repeat (3) @(negedge clk);
    $display("test lockout done");
    {raise, raiseInhib, seq} = {2'b11, 7'b0110100};
    tick();
    {raise, raiseInhib, raiseLevel} = {2'b10, 7'h5A};
    tick();
    raise = 1'b0;
    tick();
    seq = 7'b1000000;
    tick();
    seq = '0;
    for (int i = 0; i < 4 && imam !== 1'b1; i++) tick();
    chk("int addr", 24'h0000DA, memAddr);
    chk("int access", 2'b11, {imam, bit7});
    {instrWord, stat.protectError} = {24'hA5C3E1, 1'b1};
    tick();
    chk("protect addr", 24'h000010, memAddr);
    chk("int end", 1'b0, imam);
    {stat.protectError, stat.stallAlarm} = 2'b01;
    tick();
    chk("stall", 24'h000014, memAddr);
    $display("test vectors done");
    for (int i = 0; i < 600; i++) begin
      cmd = aig_cmd_t'(27'h1 << ($unsigned($random(seed)) % 27));
      {seq, stat, raise, raiseInhib, raiseLevel} = 26'($random(seed));
      instrWord = 24'($random(seed));
      accumulator = 24'($random(seed));
      restoreWord = 24'($random(seed));
      tick();
    end
    $display("test random done");
    final_report();
  end
endmodule
`default_nettype wire
